// File: i2c_wake_pkg.sv
// Purpose: shared constants and types of the two-wire wakeup and bus enable controller
// Assumes: 125 MHz system clock, AXI4-Lite register access with 32-bit data
// Notes: all offsets are byte addresses, one aligned word per register
package i2c_wake_pkg;
  // register bus geometry and answers
  localparam int ADDR_W = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // register offsets
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_FLAG = 5'h04;
  localparam logic [4:0] OFF_OWN = 5'h08;
  localparam logic [4:0] OFF_DATA = 5'h0C;
  localparam logic [4:0] OFF_STAT = 5'h10;
  localparam logic [4:0] OFF_MASK = 5'h14;
  localparam logic [4:0] OFF_CLK = 5'h18;
  // bus_control_register fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_STT = 1;
  localparam int CTRL_SPT = 2;
  localparam int CTRL_WREL = 3;
  localparam int CTRL_SPIE = 4;
  localparam int CTRL_W = 5;
  // bus_flag_register fields
  localparam int FLAG_STCEN = 0;
  localparam int FLAG_RSVDIS = 1;
  localparam int FLAG_BSY = 2;
  localparam int FLAG_MSTS = 3;
  localparam int FLAG_WAIT = 4;
  localparam int FLAG_DIR = 5;
  // interrupt status and mask fields
  localparam int IRQ_ADDR = 0;
  localparam int IRQ_STOP = 1;
  localparam int IRQ_EXT = 2;
  localparam int IRQ_W = 3;
  // reset values
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [1:0] FLAG_RST = 2'h0;
  localparam logic [6:0] OWN_RST = 7'h00;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic [7:0] CLK_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  // timing: least hold of generated start and stop conditions
  localparam int CLK_PERIOD_PS = 8000;
  localparam int COND_HOLD_NS = 4000;
  localparam int COND_HOLD_CYC = (COND_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // software control bits, packed as stored
  typedef struct packed {
    logic stop_irq_enable;
    logic wait_release_bit;
    logic stop_trigger_bit;
    logic start_trigger_bit;
    logic operation_enable_bit;
  } ctrl_t;
  // slave side of the link
  typedef enum logic [1:0] {L_IDLE = 2'h0, L_ADDR = 2'h1, L_ACK = 2'h3, L_HOLD = 2'h2} link_state_t;
  // condition generator and reservation
  typedef enum logic [1:0] {G_IDLE = 2'h0, G_START = 2'h1, G_RSV = 2'h3, G_STOP = 2'h2} gen_state_t;
endpackage

// File: pin_sync3.sv
// Purpose: three-stage synchroniser with agreement filter for one bus pin
// Assumes: pin changes slowly against mclk_i
// Notes: output follows only when the second and third stages agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic pin_i,
  output logic level_o
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // stage one feeds stage two only
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      level_o <= RST_VAL;
    end else if (ce_i) begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_o <= s3_r;
      end
    end
  end
endmodule
`default_nettype wire

// File: i2c_wakeup_ctrl.sv
// Purpose: wakeup address filter, bus-busy tracking, condition generator and reservation
// Assumes: open-drain lines, AXI4-Lite slave, mclk_i at 125 MHz samples both lines
// Notes: data bytes after the address are not shifted; a held wait ends the slave phase
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module i2c_wakeup_ctrl #(
  parameter int HOLD_CYC = i2c_wake_pkg::COND_HOLD_CYC
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic [i2c_wake_pkg::ADDR_W-1:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [i2c_wake_pkg::ADDR_W-1:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  input wire logic serial_clock_line_i,
  output logic serial_clock_line_o,
  output logic serial_clock_line_oe_n_o,
  input wire logic serial_data_line_i,
  output logic serial_data_line_o,
  output logic serial_data_line_oe_n_o,
  output logic bus_event_irq_o
);
  localparam logic [9:0] HOLD_LAST = 10'(HOLD_CYC - 1);

  i2c_wake_pkg::ctrl_t ctrl_r;
  i2c_wake_pkg::link_state_t link_st_r;
  i2c_wake_pkg::gen_state_t gen_st_r;
  logic [1:0] flag_r;
  logic [6:0] own_r;
  logic [7:0] clk_sel_r;
  logic [7:0] data_r;
  logic [7:0] sh_r;
  logic [3:0] bitcnt_r;
  logic [9:0] cnt_r;
  logic [2:0] stat_r;
  logic [2:0] stat_nxt;
  logic [2:0] mask_r;
  logic scl_f, sda_f, scl_q, sda_q;
  logic en_q, stt_q, spt_q;
  logic busy_r, msts_r, standby_r, dir_r, ack_low_r, hold_r, mst_low_r, rsv_go_r;
  logic wr_fire, rd_fire, data_wr, wait_rel;
  logic en, en_rise, stt_rise, spt_rise;
  logic start_det, stop_det, scl_rise, scl_fall, addr_end, ext_code, addr_hit;
  logic [31:0] rd_word;
  logic rd_ok, wr_ok;

  pin_sync3 #(.RST_VAL(1'b1)) u_scl_sync (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .pin_i(serial_clock_line_i), .level_o(scl_f)
  );
  pin_sync3 #(.RST_VAL(1'b1)) u_sda_sync (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .pin_i(serial_data_line_i), .level_o(sda_f)
  );

  // line history and control edge history
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      en_q <= 1'b0;
      stt_q <= 1'b0;
      spt_q <= 1'b0;
    end else if (ce_i) begin
      scl_q <= scl_f;
      sda_q <= sda_f;
      en_q <= ctrl_r.operation_enable_bit;
      stt_q <= ctrl_r.start_trigger_bit;
      spt_q <= ctrl_r.stop_trigger_bit;
    end
  end

  // bus conditions and clock edges seen on the filtered lines
  assign en = ctrl_r.operation_enable_bit;
  assign en_rise = en & ~en_q;
  assign stt_rise = ctrl_r.start_trigger_bit & ~stt_q;
  assign spt_rise = ctrl_r.stop_trigger_bit & ~spt_q;
  assign start_det = en & scl_f & scl_q & sda_q & ~sda_f;
  assign stop_det = en & scl_f & scl_q & ~sda_q & sda_f;
  assign scl_rise = scl_f & ~scl_q;
  assign scl_fall = ~scl_f & scl_q;
  assign addr_end = (link_st_r == i2c_wake_pkg::L_ADDR) & scl_fall & (bitcnt_r == 4'h8) & ~start_det & ~stop_det;
  assign ext_code = (sh_r[7:4] == 4'h0) | (sh_r[7:4] == 4'hF);
  assign addr_hit = (sh_r[7:1] == own_r) | ext_code;
  assign data_wr = wr_fire & wr_ok & (awaddr_i == i2c_wake_pkg::OFF_DATA);
  assign wait_rel = ctrl_r.wait_release_bit | data_wr | (msts_r & (stt_rise | spt_rise));

  // slave side: wakeup standby, address shift, acknowledge and wait
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      link_st_r <= i2c_wake_pkg::L_IDLE;
      standby_r <= 1'b0;
      sh_r <= 8'h00;
      bitcnt_r <= 4'h0;
      ack_low_r <= 1'b0;
      hold_r <= 1'b0;
      dir_r <= 1'b0;
    end else if (ce_i) begin
      if (!en || stop_det) begin
        link_st_r <= i2c_wake_pkg::L_IDLE;
        standby_r <= 1'b0;
        ack_low_r <= 1'b0;
        hold_r <= 1'b0;
      end else if (start_det) begin
        link_st_r <= i2c_wake_pkg::L_ADDR;
        standby_r <= 1'b1;
        bitcnt_r <= 4'h0;
        ack_low_r <= 1'b0;
        hold_r <= 1'b0;
      end else begin
        unique case (link_st_r)
          i2c_wake_pkg::L_IDLE: begin
            hold_r <= 1'b0;
          end
          i2c_wake_pkg::L_ADDR: begin
            if (scl_rise && bitcnt_r != 4'h8) begin
              sh_r <= {sh_r[6:0], sda_f};
              bitcnt_r <= bitcnt_r + 4'h1;
            end else if (addr_end) begin
              if (addr_hit) begin
                link_st_r <= i2c_wake_pkg::L_ACK;
                ack_low_r <= 1'b1;
                standby_r <= 1'b0;
                dir_r <= sh_r[0];
              end else begin
                link_st_r <= i2c_wake_pkg::L_IDLE;
              end
            end
          end
          i2c_wake_pkg::L_ACK: begin
            if (scl_fall) begin
              ack_low_r <= 1'b0;
              hold_r <= 1'b1;
              link_st_r <= i2c_wake_pkg::L_HOLD;
            end
          end
          i2c_wake_pkg::L_HOLD: begin
            if (wait_rel) begin
              hold_r <= 1'b0;
              link_st_r <= i2c_wake_pkg::L_IDLE;
            end
          end
        endcase
      end
    end
  end

  // bus busy: forced on enabling, then follows the bus
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_r <= 1'b0;
    end else if (ce_i) begin
      if (!en) begin
        busy_r <= 1'b0;
      end else if (en_rise) begin
        busy_r <= ~flag_r[i2c_wake_pkg::FLAG_STCEN];
      end else if (start_det) begin
        busy_r <= 1'b1;
      end else if (stop_det) begin
        busy_r <= 1'b0;
      end
    end
  end

  // condition generator, master flag and reservation
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gen_st_r <= i2c_wake_pkg::G_IDLE;
      cnt_r <= 10'h000;
      mst_low_r <= 1'b0;
      msts_r <= 1'b0;
      rsv_go_r <= 1'b0;
    end else if (ce_i) begin
      if (!en) begin
        gen_st_r <= i2c_wake_pkg::G_IDLE;
        mst_low_r <= 1'b0;
        msts_r <= 1'b0;
        rsv_go_r <= 1'b0;
      end else begin
        if (stop_det) begin
          msts_r <= 1'b0;
        end
        unique case (gen_st_r)
          i2c_wake_pkg::G_IDLE: begin
            cnt_r <= 10'h000;
            if (spt_rise) begin
              gen_st_r <= i2c_wake_pkg::G_STOP;
              mst_low_r <= 1'b1;
            end else if (stt_rise && !busy_r) begin
              gen_st_r <= i2c_wake_pkg::G_START;
              mst_low_r <= 1'b1;
            end else if (stt_rise && !flag_r[i2c_wake_pkg::FLAG_RSVDIS]) begin
              gen_st_r <= i2c_wake_pkg::G_RSV;
            end
          end
          i2c_wake_pkg::G_START: begin
            if (cnt_r == HOLD_LAST) begin
              msts_r <= 1'b1;
              gen_st_r <= i2c_wake_pkg::G_IDLE;
            end else begin
              cnt_r <= cnt_r + 10'h001;
            end
          end
          i2c_wake_pkg::G_STOP: begin
            if (cnt_r == HOLD_LAST) begin
              mst_low_r <= 1'b0;
              gen_st_r <= i2c_wake_pkg::G_IDLE;
            end else begin
              cnt_r <= cnt_r + 10'h001;
            end
          end
          i2c_wake_pkg::G_RSV: begin
            cnt_r <= 10'h000;
            if (rsv_go_r && data_wr) begin
              gen_st_r <= i2c_wake_pkg::G_START;
              mst_low_r <= 1'b1;
              rsv_go_r <= 1'b0;
            end else if (stop_det && ctrl_r.stop_irq_enable) begin
              rsv_go_r <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // sticky address and stop events, extension bit rewritten on each wakeup match; a set in the clearing cycle wins
  always_comb begin
    stat_nxt = stat_r;
    if (wr_fire && wr_ok && wstrb_i[0] && awaddr_i == i2c_wake_pkg::OFF_STAT) begin
      stat_nxt = stat_r & ~wdata_i[2:0];
    end
    if (ce_i && addr_end && addr_hit && standby_r) begin
      stat_nxt[i2c_wake_pkg::IRQ_ADDR] = 1'b1;
      stat_nxt[i2c_wake_pkg::IRQ_EXT] = ext_code;
    end
    if (ce_i && stop_det && ctrl_r.stop_irq_enable) begin
      stat_nxt[i2c_wake_pkg::IRQ_STOP] = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stat_r <= 3'h0;
      bus_event_irq_o <= 1'b0;
    end else if (ce_i) begin
      stat_r <= stat_nxt;
      bus_event_irq_o <= |(stat_r & mask_r);
    end
  end

  // pin drivers: lines only ever pulled low
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      serial_clock_line_o <= 1'b0;
      serial_data_line_o <= 1'b0;
      serial_clock_line_oe_n_o <= 1'b1;
      serial_data_line_oe_n_o <= 1'b1;
    end else if (ce_i) begin
      serial_clock_line_oe_n_o <= ~hold_r;
      serial_data_line_oe_n_o <= ~(ack_low_r | mst_low_r);
    end
  end

  // software registers
  assign wr_fire = awready_o & awvalid_i & wvalid_i;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_r <= i2c_wake_pkg::CTRL_RST;
      flag_r <= i2c_wake_pkg::FLAG_RST;
      own_r <= i2c_wake_pkg::OWN_RST;
      mask_r <= i2c_wake_pkg::MASK_RST;
      clk_sel_r <= i2c_wake_pkg::CLK_RST;
      data_r <= i2c_wake_pkg::DATA_RST;
    end else if (ce_i) begin
      ctrl_r.wait_release_bit <= 1'b0;
      if (wr_fire && wstrb_i[0]) begin
        unique case (awaddr_i)
          i2c_wake_pkg::OFF_CTRL: ctrl_r <= wdata_i[i2c_wake_pkg::CTRL_W-1:0];
          i2c_wake_pkg::OFF_FLAG: flag_r <= wdata_i[1:0];
          i2c_wake_pkg::OFF_OWN: own_r <= wdata_i[6:0];
          i2c_wake_pkg::OFF_DATA: data_r <= wdata_i[7:0];
          i2c_wake_pkg::OFF_MASK: mask_r <= wdata_i[2:0];
          i2c_wake_pkg::OFF_CLK: begin
            if (!en) begin
              clk_sel_r <= wdata_i[7:0];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case (araddr_i)
      i2c_wake_pkg::OFF_CTRL: rd_word[4:0] = ctrl_r;
      i2c_wake_pkg::OFF_FLAG: rd_word[5:0] = {dir_r, hold_r | (gen_st_r == i2c_wake_pkg::G_RSV), msts_r, busy_r, flag_r};
      i2c_wake_pkg::OFF_OWN: rd_word[6:0] = own_r;
      i2c_wake_pkg::OFF_DATA: rd_word[7:0] = (link_st_r == i2c_wake_pkg::L_IDLE) ? data_r : sh_r;
      i2c_wake_pkg::OFF_STAT: rd_word[2:0] = stat_r;
      i2c_wake_pkg::OFF_MASK: rd_word[2:0] = mask_r;
      i2c_wake_pkg::OFF_CLK: rd_word[7:0] = clk_sel_r;
      default: rd_ok = 1'b0;
    endcase
  end
  assign wr_ok = (awaddr_i == i2c_wake_pkg::OFF_CTRL) | (awaddr_i == i2c_wake_pkg::OFF_FLAG) |
                 (awaddr_i == i2c_wake_pkg::OFF_OWN) | (awaddr_i == i2c_wake_pkg::OFF_DATA) |
                 (awaddr_i == i2c_wake_pkg::OFF_STAT) | (awaddr_i == i2c_wake_pkg::OFF_MASK) |
                 (awaddr_i == i2c_wake_pkg::OFF_CLK);
  assign rd_fire = arready_o & arvalid_i;

  // bus handshakes: both write channels taken together
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      awready_o <= 1'b0;
      wready_o <= 1'b0;
      bvalid_o <= 1'b0;
      bresp_o <= i2c_wake_pkg::RESP_OKAY;
      arready_o <= 1'b0;
      rvalid_o <= 1'b0;
      rdata_o <= 32'h0000_0000;
      rresp_o <= i2c_wake_pkg::RESP_OKAY;
    end else if (ce_i) begin
      awready_o <= awvalid_i & wvalid_i & ~awready_o & ~bvalid_o;
      wready_o <= awvalid_i & wvalid_i & ~awready_o & ~bvalid_o;
      if (wr_fire) begin
        bvalid_o <= 1'b1;
        bresp_o <= wr_ok ? i2c_wake_pkg::RESP_OKAY : i2c_wake_pkg::RESP_SLVERR;
      end else if (bready_i) begin
        bvalid_o <= 1'b0;
      end
      arready_o <= arvalid_i & ~arready_o & ~rvalid_o;
      if (rd_fire) begin
        rvalid_o <= 1'b1;
        rdata_o <= rd_word;
        rresp_o <= rd_ok ? i2c_wake_pkg::RESP_OKAY : i2c_wake_pkg::RESP_SLVERR;
      end else if (rready_i) begin
        rvalid_o <= 1'b0;
      end
    end
  end

  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_held;
    link_st_r == i2c_wake_pkg::L_HOLD && !serial_clock_line_oe_n_o;
  endsequence
  sequence s_freed;
    link_st_r == i2c_wake_pkg::L_IDLE ##1 serial_clock_line_oe_n_o;
  endsequence
  a_addr_miss_quiet: assert property (ce_i && addr_end && !addr_hit |=> !$rose(stat_r[0]) && link_st_r == 2'h0)
    else $error("address mismatch raised an event");
  a_addr_hit_event: assert property (ce_i && addr_end && addr_hit && standby_r |=> stat_r[0])
    else $error("address match raised no event");
  a_start_standby: assert property (ce_i && start_det && !stop_det |=> standby_r && link_st_r == 2'h1)
    else $error("start did not enter standby");
  a_stop_event_gate: assert property (ce_i && stop_det && !(wr_fire && awaddr_i == i2c_wake_pkg::OFF_STAT)
    |=> stat_r[1] == ($past(ctrl_r.stop_irq_enable) | $past(stat_r[1])))
    else $error("stop event not gated by its enable");
  a_busy_forced_one: assert property (ce_i && en_rise && !flag_r[0] |=> busy_r)
    else $error("busy not forced high");
  a_busy_forced_zero: assert property (ce_i && en_rise && flag_r[0] |=> !busy_r)
    else $error("busy not forced low");
  a_busy_tracks_bus: assert property (ce_i && !en_rise && start_det |=> busy_r ##0 $stable(en)[*1])
    else $error("busy ignored start");
  a_rsv_halted: assert property (ce_i && en && gen_st_r == 2'h3 && !rsv_go_r && !(stop_det && ctrl_r.stop_irq_enable)
    |=> gen_st_r == 2'h3 && mst_low_r == $past(mst_low_r))
    else $error("reservation left halt without stop event");
  a_rsv_launch: assert property (ce_i && en && gen_st_r == 2'h3 && rsv_go_r && data_wr |=> gen_st_r == 2'h1 ##1 mst_low_r)
    else $error("data write did not launch reserved start");
  a_rsv_disabled: assert property (ce_i && en && gen_st_r == 2'h0 && stt_rise && busy_r && !spt_rise
    |=> (gen_st_r == 2'h3) == !$past(flag_r[1]))
    else $error("reservation disable bit ignored");
  a_master_read: assert property (rd_fire && ce_i && araddr_i == i2c_wake_pkg::OFF_FLAG |=> rdata_o[3] == $past(msts_r))
    else $error("master flag not readable");
  a_wait_release: assert property (((ce_i && en && !stop_det && !start_det && wait_rel) and s_held) |=> s_freed)
    else $error("wait not released");
endmodule
`default_nettype wire

// File: i2c_master_model.sv
// Purpose: far-side bus master that frames start, address bytes and stop on the two-wire bus
// Assumes: lines are open drain with pull-ups, one data bit takes 8 mclk cycles (64 ns), the ack bit longer
// Notes: the clock stands still high outside frames; a released line reads high
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  input wire logic clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // quarter and half bit steps counted in mclk cycles
  task automatic q();
    repeat (2) @(posedge clk_i);
  endtask
  task automatic h();
    repeat (4) @(posedge clk_i);
  endtask
  // data falls while the clock is high
  task automatic start();
    sda_o <= 1'b0;
    h();
    scl_o <= 1'b0;
    h();
  endtask
  // msb first, data changes only in the clock low phase, ack sampled on the ninth high
  // a high ninth bit is a withheld acknowledge and ends the transfer
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      q();
      sda_o <= b[i];
      q();
      scl_o <= 1'b1;
      h();
      scl_o <= 1'b0;
    end
    q();
    sda_o <= 1'b1;
    h();
    h();
    scl_o <= 1'b1;
    h();
    ack = sda_i;
    scl_o <= 1'b0;
    h();
  endtask
  // waits while the device stretches the clock, then data rises while the clock is high
  task automatic stop();
    q();
    sda_o <= 1'b0;
    q();
    scl_o <= 1'b1;
    for (int n = 0; n < 400 && scl_i !== 1'b1; n++) @(posedge clk_i);
    h();
    sda_o <= 1'b1;
    h();
  endtask
endmodule
`default_nettype wire

// File: i2c_wakeup_ctrl_tb.sv
// Purpose: self-checking bench of the wakeup filter, busy tracking and reservation
// Assumes: 125 MHz mclk_i, short condition hold, bus master model on the lines
// Notes: registers reached through AXI4-Lite tasks with bounded waits
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", n, e, s); end end
module i2c_wakeup_ctrl_tb;
  logic mclk_i = 0, arst_n_i = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, irq, scl_o, scl_oe_n, sda_o, sda_oe_n, m_scl, m_sda, ack;
  logic [4:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [1:0] bresp, rresp;
  int err_count = 0, num_checks = 0;
  // wired-and of both parties on each open-drain line
  wire scl = m_scl & (scl_oe_n | scl_o);
  wire sda = m_sda & (sda_oe_n | sda_o);
  i2c_wakeup_ctrl #(.HOLD_CYC(4)) dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .ce_i(1'b1),
    .awaddr_i(awaddr), .awvalid_i(awvalid), .awready_o(awready), .wdata_i(wdata), .wstrb_i(4'hF),
    .wvalid_i(wvalid), .wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid), .bready_i(bready),
    .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready), .rdata_o(rdata), .rresp_o(rresp),
    .rvalid_o(rvalid), .rready_i(rready), .serial_clock_line_i(scl), .serial_clock_line_o(scl_o),
    .serial_clock_line_oe_n_o(scl_oe_n), .serial_data_line_i(sda), .serial_data_line_o(sda_o),
    .serial_data_line_oe_n_o(sda_oe_n), .bus_event_irq_o(irq));
  i2c_master_model m (.clk_i(mclk_i), .scl_i(scl), .sda_i(sda), .scl_o(m_scl), .sda_o(m_sda));
  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", err_count, num_checks);
    if (err_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 40) begin
      err_count++;
      $display("CHECK FAILED handshake expected 1 seen 0");
      give_verdict();
    end
  endtask
  // write: address and data offered together, then response
  task automatic wr(input logic [4:0] a, input logic [31:0] v, input logic [1:0] er = 2'h0);
    int n;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    n = 0;
    do begin @(posedge mclk_i); n++; end while (awready !== 1'b1 && n < 40);
    tmo(n);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    n = 0;
    do begin @(posedge mclk_i); n++; end while (bvalid !== 1'b1 && n < 40);
    tmo(n);
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] v, input logic [1:0] er = 2'h0);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    n = 0;
    do begin @(posedge mclk_i); n++; end while (arready !== 1'b1 && n < 40);
    tmo(n);
    arvalid <= 1'b0;
    rready <= 1'b1;
    n = 0;
    do begin @(posedge mclk_i); n++; end while (rvalid !== 1'b1 && n < 40);
    tmo(n);
    v = rdata;
    rready <= 1'b0;
    `CHK("rresp", er, rresp)
  endtask
  task automatic wctl(input logic [31:0] v);
    wr(i2c_wake_pkg::OFF_CTRL, v);
  endtask
  task automatic fl(input int b, input logic v);
    rd(i2c_wake_pkg::OFF_FLAG, d);
    `CHK("flag bit", v, d[b])
  endtask
  // status check followed by write-one clear
  task automatic st(input logic [2:0] v);
    rd(i2c_wake_pkg::OFF_STAT, d);
    `CHK("status", v, d[2:0])
    wr(i2c_wake_pkg::OFF_STAT, 32'h7);
  endtask
  task automatic wirq(input logic v);
    for (int n = 0; n < 200 && irq !== v; n++) @(posedge mclk_i);
    `CHK("irq", v, irq)
  endtask
  // disable, options, clock, mask, then enable with lines idle high
  task automatic en(input logic opt, input logic dis, input logic spie);
    wctl(32'h0);
    wr(i2c_wake_pkg::OFF_FLAG, {dis, opt});
    wr(i2c_wake_pkg::OFF_CLK, 32'h3C);
    wr(i2c_wake_pkg::OFF_MASK, 32'h7);
    wctl({spie, 4'h1});
  endtask
  task automatic s_regs();
    rd(i2c_wake_pkg::OFF_CTRL, d);
    `CHK("ctrl reset", 32'h0, d)
    wr(5'h1C, 32'h1, i2c_wake_pkg::RESP_SLVERR);
    rd(5'h1C, d, i2c_wake_pkg::RESP_SLVERR);
    `CHK("unmapped data", 32'h0, d)
  endtask
  task automatic s_busy();
    en(1'b0, 1'b0, 1'b0);
    fl(i2c_wake_pkg::FLAG_BSY, 1'b1);
    wctl(32'h5);
    repeat (30) @(posedge mclk_i);
    fl(i2c_wake_pkg::FLAG_BSY, 1'b0);
    m.start();
    fl(i2c_wake_pkg::FLAG_BSY, 1'b1);
    m.stop();
    fl(i2c_wake_pkg::FLAG_BSY, 1'b0);
    en(1'b1, 1'b0, 1'b0);
    fl(i2c_wake_pkg::FLAG_BSY, 1'b0);
  endtask
  task automatic s_wake();
    en(1'b0, 1'b0, 1'b0);
    wr(i2c_wake_pkg::OFF_OWN, 32'h2A);
    m.start();
    m.send(8'h36, ack);
    `CHK("mismatch ack", 1'b1, ack)
    `CHK("mismatch irq", 1'b0, irq)
    m.stop();
    wirq(1'b0);
    m.start();
    m.send(8'h54, ack);
    `CHK("match ack", 1'b0, ack)
    wirq(1'b1);
    repeat (4) @(posedge mclk_i);
    `CHK("scl held", 1'b0, scl_oe_n)
    wctl(32'h9);
    repeat (10) @(posedge mclk_i);
    `CHK("scl released", 1'b1, scl_oe_n)
    st(3'h1);
    wirq(1'b0);
    m.stop();
    wctl(32'h11);
    wr(i2c_wake_pkg::OFF_MASK, 32'h5);
    m.start();
    m.send(8'hF0, ack);
    wirq(1'b1);
    st(3'h5);
    wirq(1'b0);
    wctl(32'h19);
    m.stop();
    repeat (20) @(posedge mclk_i);
    `CHK("masked irq", 1'b0, irq)
    st(3'h2);
  endtask
  task automatic s_rsv();
    en(1'b0, 1'b0, 1'b1);
    wctl(32'h13);
    fl(i2c_wake_pkg::FLAG_WAIT, 1'b1);
    m.start();
    m.stop();
    wirq(1'b1);
    st(3'h2);
    wr(i2c_wake_pkg::OFF_DATA, 32'hA5);
    repeat (10) @(posedge mclk_i);
    `CHK("start sda", 1'b0, sda_oe_n)
    fl(i2c_wake_pkg::FLAG_MSTS, 1'b1);
    wctl(32'h11);
    wctl(32'h15);
    repeat (30) @(posedge mclk_i);
    `CHK("stop sda", 1'b1, sda_oe_n)
    fl(i2c_wake_pkg::FLAG_MSTS, 1'b0);
    en(1'b0, 1'b0, 1'b0);
    wctl(32'h3);
    m.start();
    m.stop();
    wr(i2c_wake_pkg::OFF_DATA, 32'h5A);
    repeat (10) @(posedge mclk_i);
    `CHK("halted sda", 1'b1, sda_oe_n)
    fl(i2c_wake_pkg::FLAG_WAIT, 1'b1);
    en(1'b0, 1'b1, 1'b0);
    wctl(32'h3);
    fl(i2c_wake_pkg::FLAG_WAIT, 1'b0);
  endtask
  // clock, reset and main sequence
  initial forever #4 mclk_i = ~mclk_i;
  initial begin
    repeat (4) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    @(posedge mclk_i);
    s_regs();
    s_busy();
    s_wake();
    s_rsv();
    give_verdict();
  end
endmodule
`default_nettype wire
